// [common/uart_irq_pkg.sv]
// Constants and encodings shared by the UART interrupt status logic.
`default_nettype none
package uart_irq_pkg;

    // ========================================================================
    // Sources, ordered from the highest priority to the lowest
    // ========================================================================
    localparam int NUM_SRC = 7;
    localparam int CNT_W   = 6;

    typedef enum logic [2:0] {
        SRC_LINE    = 3'h0,
        SRC_RECEIVE_DATA_AVAILABLE   = 3'h1,
        SRC_TIMEOUT = 3'h2,
        SRC_THR     = 3'h3,
        SRC_MODEM   = 3'h4,
        SRC_XOFF    = 3'h5,
        SRC_FLOW    = 3'h6
    } src_type;

    // ========================================================================
    // Six-bit interrupt codes in status bits 5 down to 0
    // ========================================================================
    localparam logic [5:0] CODE_LINE    = 6'h06;
    localparam logic [5:0] CODE_RECEIVE_DATA_AVAILABLE   = 6'h04;
    localparam logic [5:0] CODE_TIMEOUT = 6'h0C;
    localparam logic [5:0] CODE_THR     = 6'h02;
    localparam logic [5:0] CODE_MODEM   = 6'h00;
    localparam logic [5:0] CODE_XOFF    = 6'h10;
    localparam logic [5:0] CODE_FLOW    = 6'h20;
    localparam logic [5:0] CODE_NONE    = 6'h01;

    // ========================================================================
    // Register map, byte addresses
    // ========================================================================
    localparam int         ADDR_W         = 5;
    localparam logic [4:0] OFS_ISR        = 5'h00;
    localparam logic [4:0] OFS_IRQ_ENABLE = 5'h04;
    localparam logic [4:0] OFS_FIFO_SETUP = 5'h08;
    localparam logic [4:0] OFS_ENH_FEAT   = 5'h0C;
    localparam logic [4:0] OFS_PENDING    = 5'h10;

    // ========================================================================
    // Field positions and reset values
    // ========================================================================
    localparam int FIFO_EN_BIT  = 0;
    localparam int TX_TRIG_LSB  = 4;
    localparam int RX_TRIG_LSB  = 6;
    localparam int ENH_BIT      = 4;
    localparam int ISR_IDLE_BIT = 0;
    localparam int ISR_FIFO_LSB = 6;

    localparam logic [6:0] IRQ_ENABLE_RESET = 7'h00;
    localparam logic [7:0] FIFO_SETUP_RESET = 8'h00;
    localparam logic [7:0] ENH_FEAT_RESET   = 8'h00;

    // ========================================================================
    // FIFO trigger levels, indexed by the two-bit select field
    // ========================================================================
    localparam logic [5:0] RX_TRIG_TABLE [4] = '{6'h08, 6'h10, 6'h18, 6'h1C};
    localparam logic [5:0] TX_TRIG_TABLE [4] = '{6'h10, 6'h08, 6'h18, 6'h1E};

endpackage
`default_nettype wire

// [common/irq_arb_if.sv]
// Carrier between the status register logic and the priority arbiter.
`timescale 1ns/100ps
`default_nettype none
interface irq_arb_if;
    logic [6:0] pending;
    logic       valid;
    logic [2:0] idx;

    modport arb  (input pending, output valid, output idx);
    modport user (output pending, input valid, input idx);
endinterface
`default_nettype wire

// [rtl/irq_priority_arbiter.sv]
// Fixed-priority pick of the highest pending interrupt source.
`timescale 1ns/100ps
`default_nettype none
module irq_priority_arbiter
    import uart_irq_pkg::*;
(
    irq_arb_if.arb arb
);

    // ========================================================================
    // Lowest index wins; the loop runs downward so the last hit stands
    // ========================================================================
    always_comb begin
        arb.valid = 1'b0;
        arb.idx   = 3'h0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (arb.pending[i]) begin
                arb.valid = 1'b1;
                arb.idx   = 3'(i);
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/uart_interrupt_priority_status.sv]
// Interrupt prioritisation and status register of the UART, Avalon-MM slave.
//
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Sources rank in six fixed levels, level 1 highest, and arbitrate by rank.
// - Reading the status register returns the reported interrupt code, the highest pending when it was chosen.
// - A reported interrupt stays reported until serviced, ahead of any other.
// - A status read clears only the reported interrupt; others stay pending.
// - After a clearing read, the next read shows the next pending interrupt.
// - Line status is level 1, code bits 2 and 1 set.
// - Received data ready is level 2, code bit 2 set.
// - Receive time-out shares level 2, code bits 3 and 2 set.
// - Transmit holding empty is level 3, code bit 1 set.
// - Modem status is level 4, code all zeros.
// - Xoff or special character is level 5, code bit 4 set.
// - Flow line change is level 6, code bit 5 set.
// - Status bits 7 and 6 read one with FIFOs enabled, else zero.
// - Status bits 5 and 4 report only when enhanced bit 4 is set.
// - Xoff indication stays set until Xon characters arrive.
// - Status bits 3 to 1 identify levels 1 to 3; default zero.
// - Status bit 0 reads zero when pending, one when idle; resets to one.
// - FIFO enable bit selects trigger-level mode and drives status bits 7 and 6.
// - In FIFO mode receive ready rises when fill equals receive trigger.
// - In FIFO mode transmit empty rises when fill drops below transmit trigger.
module uart_interrupt_priority_status
    import uart_irq_pkg::*;
(
    input  wire logic               i_clock,
    input  wire logic               i_rst_n,
    input  wire logic [ADDR_W-1:0]  i_address,
    input  wire logic               i_read,
    input  wire logic               i_write,
    input  wire logic [3:0]         i_byteenable,
    input  wire logic [31:0]        i_writedata,
    output logic      [31:0]        o_readdata,
    output logic                    o_waitrequest,
    input  wire logic               i_line_status_event,
    input  wire logic               i_rx_data_ready,
    input  wire logic               i_rx_timeout,
    input  wire logic               i_thr_empty,
    input  wire logic               i_modem_status_event,
    input  wire logic               i_xoff_detect,
    input  wire logic               i_xon_detect,
    input  wire logic               i_flow_change,
    input  wire logic [CNT_W-1:0]   i_rx_fifo_count,
    input  wire logic [CNT_W-1:0]   i_tx_fifo_count
);

    // ========================================================================
    // State
    // ========================================================================
    typedef struct packed {
        logic        waitreq;
        logic [31:0] rdata;
        logic [6:0]  pend;
        logic        rep_valid;
        logic [2:0]  rep_idx;
        logic        snap_isr;
        logic        snap_valid;
        logic [2:0]  snap_idx;
        logic [6:0]  irq_enable;
        logic [7:0]  fifo_setup;
        logic [7:0]  enh_feat;
        logic        rx_rdy_prev;
        logic        thr_prev;
        logic        rx_trig_prev;
        logic        tx_trig_prev;
    } state_type;

    state_type state_q;
    state_type state_d;

    irq_arb_if arb_bus ();

    irq_priority_arbiter u_arbiter (
        .arb (arb_bus.arb)
    );

    logic             req;
    logic             accept;
    logic             fifo_en;
    logic [5:0]       rx_trig;
    logic [5:0]       tx_trig;
    logic             rx_at_trig;
    logic             tx_below;
    logic [6:0]       set_vec;
    logic [6:0]       clr_vec;
    logic [6:0]       en_mask;
    logic [6:0]       masked;
    logic             cur_valid;
    logic [2:0]       cur_idx;
    logic [7:0]       isr_value;

    // ========================================================================
    // Code lookup
    // ========================================================================
    function automatic logic [5:0] code_of(input logic [2:0] idx);
        case (src_type'(idx))
            SRC_LINE:    code_of = CODE_LINE;
            SRC_RECEIVE_DATA_AVAILABLE:   code_of = CODE_RECEIVE_DATA_AVAILABLE;
            SRC_TIMEOUT: code_of = CODE_TIMEOUT;
            SRC_THR:     code_of = CODE_THR;
            SRC_MODEM:   code_of = CODE_MODEM;
            SRC_XOFF:    code_of = CODE_XOFF;
            SRC_FLOW:    code_of = CODE_FLOW;
            default:     code_of = CODE_MODEM;
        endcase
    endfunction

    // ========================================================================
    // Next state
    // ========================================================================
    always_comb begin
        state_d = state_q;
        req     = i_read | i_write;
        accept  = req & ~state_q.waitreq;
        fifo_en = state_q.fifo_setup[FIFO_EN_BIT];

        rx_trig    = RX_TRIG_TABLE[state_q.fifo_setup[RX_TRIG_LSB +: 2]];
        tx_trig    = TX_TRIG_TABLE[state_q.fifo_setup[TX_TRIG_LSB +: 2]];
        rx_at_trig = (i_rx_fifo_count == rx_trig);
        tx_below   = (i_tx_fifo_count < tx_trig);

        // Data ready and holding empty are taken on their rising edge so a level that stays high
        // does not re-arm the flag right after a clearing read.
        set_vec              = 7'h00;
        set_vec[SRC_LINE]    = i_line_status_event;
        set_vec[SRC_RECEIVE_DATA_AVAILABLE]   = fifo_en ? (rx_at_trig & ~state_q.rx_trig_prev)
                                       : (i_rx_data_ready & ~state_q.rx_rdy_prev);
        set_vec[SRC_TIMEOUT] = i_rx_timeout;
        set_vec[SRC_THR]     = fifo_en ? (tx_below & ~state_q.tx_trig_prev)
                                       : (i_thr_empty & ~state_q.thr_prev);
        set_vec[SRC_MODEM]   = i_modem_status_event;
        set_vec[SRC_XOFF]    = i_xoff_detect;
        set_vec[SRC_FLOW]    = i_flow_change;

        state_d.rx_rdy_prev  = i_rx_data_ready;
        state_d.thr_prev     = i_thr_empty;
        state_d.rx_trig_prev = rx_at_trig;
        state_d.tx_trig_prev = tx_below;

        // Xoff and flow sources, on bits 5 and 6, take part only with enhanced features on.
        en_mask               = state_q.irq_enable;
        en_mask[SRC_XOFF]     = en_mask[SRC_XOFF] & state_q.enh_feat[ENH_BIT];
        en_mask[SRC_FLOW]     = en_mask[SRC_FLOW] & state_q.enh_feat[ENH_BIT];
        masked                = state_q.pend & en_mask;
        arb_bus.pending       = masked;

        // The reported source holds even if a higher one arrives later.
        if (state_q.rep_valid && masked[state_q.rep_idx]) begin
            cur_valid = 1'b1;
            cur_idx   = state_q.rep_idx;
        end else begin
            cur_valid = arb_bus.valid;
            cur_idx   = arb_bus.idx;
        end
        state_d.rep_valid = cur_valid;
        state_d.rep_idx   = cur_idx;

        isr_value                      = 8'h00;
        isr_value[ISR_FIFO_LSB +: 2]   = {fifo_en, fifo_en};
        if (cur_valid) begin
            isr_value[5:0] = code_of(cur_idx);
        end else begin
            isr_value[5:0] = CODE_NONE;
        end

        // Bus slave: one wait cycle, then the access completes.
        clr_vec = 7'h00;
        if (req && state_q.waitreq) begin
            state_d.waitreq    = 1'b0;
            state_d.snap_isr   = 1'b0;
            state_d.snap_valid = cur_valid;
            state_d.snap_idx   = cur_idx;
            if (i_address == OFS_ISR) begin
                state_d.rdata    = {24'h000000, isr_value};
                state_d.snap_isr = 1'b1;
            end else if (i_address == OFS_IRQ_ENABLE) begin
                state_d.rdata = {25'h0000000, state_q.irq_enable};
            end else if (i_address == OFS_FIFO_SETUP) begin
                state_d.rdata = {24'h000000, state_q.fifo_setup};
            end else if (i_address == OFS_ENH_FEAT) begin
                state_d.rdata = {24'h000000, state_q.enh_feat};
            end else if (i_address == OFS_PENDING) begin
                state_d.rdata = {25'h0000000, state_q.pend};
            end else begin
                state_d.rdata = 32'h00000000;
            end
        end else begin
            state_d.waitreq = 1'b1;
        end

        if (accept && i_write && i_byteenable[0]) begin
            if (i_address == OFS_IRQ_ENABLE) begin
                state_d.irq_enable = i_writedata[6:0];
            end else if (i_address == OFS_FIFO_SETUP) begin
                state_d.fifo_setup = i_writedata[7:0];
            end else if (i_address == OFS_ENH_FEAT) begin
                state_d.enh_feat = i_writedata[7:0];
            end
        end

        // Only the source shown by this read is cleared; Xoff waits for Xon.
        if (accept && i_read && state_q.snap_isr && state_q.snap_valid &&
            state_q.snap_idx != SRC_XOFF) begin
            clr_vec = 7'(7'h01 << state_q.snap_idx);
        end
        clr_vec[SRC_XOFF] = i_xon_detect;

        // A new event in the clearing cycle survives the clear.
        state_d.pend = (state_q.pend & ~clr_vec) | set_vec;
    end

    // ========================================================================
    // Registers
    // ========================================================================
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q            <= '0;
            state_q.waitreq    <= 1'b1;
            state_q.irq_enable <= IRQ_ENABLE_RESET;
            state_q.fifo_setup <= FIFO_SETUP_RESET;
            state_q.enh_feat   <= ENH_FEAT_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_readdata    = state_q.rdata;
    assign o_waitrequest = state_q.waitreq;

    // ========================================================================
    // Assertions
    // ========================================================================
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    logic isr_rd_start;
    assign isr_rd_start = req && state_q.waitreq && (i_address == OFS_ISR);

    chk_idle_bit_value: assert property (
        isr_rd_start |=> o_readdata[ISR_IDLE_BIT] == !$past(cur_valid))
        else $error("Status bit 0 disagrees with pending state.");

    chk_fifo_bits_value: assert property (
        isr_rd_start |=> o_readdata[7:6] == {2{$past(fifo_en)}})
        else $error("Status bits 7 and 6 do not follow FIFO enable.");

    chk_code_reported: assert property (
        isr_rd_start && cur_valid |=> o_readdata[5:0] == code_of($past(cur_idx)))
        else $error("Reported code does not match chosen source.");

    chk_hold_reported: assert property (
        state_q.rep_valid && masked[state_q.rep_idx]
        |=> state_q.rep_valid && state_q.rep_idx == $past(state_q.rep_idx))
        else $error("Reported source changed while still pending.");

    chk_top_priority: assert property (
        !state_q.rep_valid && masked[SRC_LINE] |-> cur_idx == SRC_LINE)
        else $error("Line status did not win a fresh arbitration.");

    chk_clear_only_one: assert property (
        accept && i_read && state_q.snap_isr && state_q.snap_valid &&
        state_q.snap_idx != SRC_XOFF && set_vec == 7'h00 && !i_xon_detect
        |=> state_q.pend == ($past(state_q.pend) & ~(7'(7'h01 << $past(state_q.snap_idx)))))
        else $error("Status read cleared more than the reported source.");

    chk_xoff_sticky: assert property (
        state_q.pend[SRC_XOFF] && !i_xon_detect |=> state_q.pend[SRC_XOFF])
        else $error("Xoff indication dropped without Xon.");

    chk_enh_gate: assert property (
        isr_rd_start && !state_q.enh_feat[ENH_BIT] |=> o_readdata[5:4] == 2'h0)
        else $error("Bits 5 and 4 reported without enhanced features.");

    chk_enable_gate: assert property (
        cur_valid |-> state_q.irq_enable[cur_idx])
        else $error("A disabled source is being reported.");

    chk_bus_answer: assert property (
        req && state_q.waitreq |=> !o_waitrequest ##1 o_waitrequest)
        else $error("Bus access did not complete after one wait cycle.");

    chk_rx_trigger: assert property (
        fifo_en && rx_at_trig && !state_q.rx_trig_prev |=> state_q.pend[SRC_RECEIVE_DATA_AVAILABLE])
        else $error("Receive trigger level did not raise data ready.");

    chk_tx_trigger: assert property (
        fifo_en && tx_below && !state_q.tx_trig_prev |=> state_q.pend[SRC_THR])
        else $error("Transmit trigger level did not raise holding empty.");

    chk_level2_tie: assert property (
        !state_q.rep_valid && masked[SRC_RECEIVE_DATA_AVAILABLE] && masked[SRC_TIMEOUT] && !masked[SRC_LINE]
        |-> cur_idx == SRC_RECEIVE_DATA_AVAILABLE)
        else $error("Time-out won over received data ready.");

    chk_next_exposed: assert property (
        accept && i_read && state_q.snap_isr && state_q.snap_valid &&
        state_q.snap_idx != SRC_XOFF && !set_vec[state_q.snap_idx]
        |=> !(cur_valid && cur_idx == $past(state_q.snap_idx)))
        else $error("Cleared source was reported again.");

    // Each level's code is held against the package table, so a slip in the
    // lookup shows up even when the arbitration itself is right.
    chk_line_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_LINE |=> o_readdata[5:0] == CODE_LINE)
        else $error("Line status code is wrong.");

    chk_receive_data_available_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_RECEIVE_DATA_AVAILABLE |=> o_readdata[5:0] == CODE_RECEIVE_DATA_AVAILABLE)
        else $error("Data ready code is wrong.");

    chk_timeout_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_TIMEOUT |=> o_readdata[5:0] == CODE_TIMEOUT)
        else $error("Receive time-out code is wrong.");

    chk_thr_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_THR |=> o_readdata[5:0] == CODE_THR)
        else $error("Holding empty code is wrong.");

    chk_modem_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_MODEM |=> o_readdata[5:0] == CODE_MODEM)
        else $error("Modem status code is wrong.");

    chk_xoff_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_XOFF |=> o_readdata[5:0] == CODE_XOFF)
        else $error("Xoff code is wrong.");

    chk_flow_code: assert property (
        isr_rd_start && cur_valid && cur_idx == SRC_FLOW |=> o_readdata[5:0] == CODE_FLOW)
        else $error("Flow change code is wrong.");

    chk_upper_levels_low: assert property (
        isr_rd_start && cur_valid && cur_idx > SRC_THR |=> o_readdata[3:1] == 3'h0)
        else $error("Bits 3 to 1 set for a level below 3.");

    cov_line_read: cover property (isr_rd_start && cur_idx == SRC_LINE && cur_valid);
    cov_two_pending: cover property (isr_rd_start && masked[SRC_LINE] && masked[SRC_THR]
                                     ##3 isr_rd_start && cur_idx == SRC_THR);
    cov_fifo_rx_read: cover property (isr_rd_start && fifo_en && cur_valid && cur_idx == SRC_RECEIVE_DATA_AVAILABLE);
    cov_idle_read: cover property (isr_rd_start && !cur_valid);
    cov_xoff_xon: cover property (state_q.pend[SRC_XOFF] ##[1:20] i_xon_detect);

endmodule
`default_nettype wire

// [test/uart_host_model.sv]
// Avalon-MM host model that reads and writes the interrupt status registers.
`timescale 1ns/100ps
`default_nettype none
module uart_host_model
    import uart_irq_pkg::*;
(
    input  wire logic              i_clock,
    input  wire logic [31:0]       i_readdata,
    input  wire logic              i_waitrequest,
    output logic      [ADDR_W-1:0] o_address,
    output logic                   o_read,
    output logic                   o_write,
    output logic      [3:0]        o_byteenable,
    output logic      [31:0]       o_writedata
);
    // ========================================================================
    // Bus cycles
    // ========================================================================
    initial begin
        o_address = '0;
        o_read = 1'b0;
        o_write = 1'b0;
        o_byteenable = 4'h0;
        o_writedata = 32'h0;
    end

    // A status read is destructive; the caller re-reads to see the next source.
    task automatic access(input logic wr, input logic [ADDR_W-1:0] addr,
                          input logic [31:0] wdata, input logic [3:0] be,
                          output logic [31:0] rdata);
        @(posedge i_clock);
        o_address <= addr;
        o_writedata <= wdata;
        o_byteenable <= be;
        o_read <= !wr;
        o_write <= wr;
        do @(posedge i_clock); while (i_waitrequest !== 1'b0);
        rdata = i_readdata;
        o_read <= 1'b0;
        o_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [test/tb_uart_interrupt_priority_status.sv]
// Self-checking testbench of the UART interrupt priority and status logic.
`timescale 1ns/100ps
`default_nettype none
module tb_uart_interrupt_priority_status;
    import uart_irq_pkg::*;
    // ========================================================================
    // Clock, reset and stimulus
    // ========================================================================
    logic              i_clock = 1'b0;
    logic              i_rst_n = 1'b0;
    logic [ADDR_W-1:0] address;
    logic              rd;
    logic              wr;
    logic [3:0]        be;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic              waitreq;
    logic [6:0]        src = 7'h00;
    logic              xon = 1'b0;
    logic [CNT_W-1:0]  rxc = 6'h00;
    logic [CNT_W-1:0]  txc = 6'h20;
    int                n_mismatch = 0;
    int                compares = 0;
    int                cycles = 0;
    logic [31:0]       seed;

    always #12.5 i_clock = ~i_clock;

    uart_interrupt_priority_status dut (
        .i_clock(i_clock), .i_rst_n(i_rst_n), .i_address(address), .i_read(rd),
        .i_write(wr), .i_byteenable(be), .i_writedata(wdata), .o_readdata(rdata),
        .o_waitrequest(waitreq), .i_line_status_event(src[0]), .i_rx_data_ready(src[1]),
        .i_rx_timeout(src[2]), .i_thr_empty(src[3]), .i_modem_status_event(src[4]),
        .i_xoff_detect(src[5]), .i_xon_detect(xon), .i_flow_change(src[6]),
        .i_rx_fifo_count(rxc), .i_tx_fifo_count(txc));

    uart_host_model host (
        .i_clock(i_clock), .i_readdata(rdata), .i_waitrequest(waitreq),
        .o_address(address), .o_read(rd), .o_write(wr), .o_byteenable(be),
        .o_writedata(wdata));

    // ========================================================================
    // Helpers
    // ========================================================================
    function automatic logic [31:0] isr_of(input int idx, input logic fifo);
        logic [5:0] c;
        case (idx)
            0: c = 6'h06;
            1: c = 6'h04;
            2: c = 6'h0C;
            3: c = 6'h02;
            4: c = 6'h00;
            5: c = 6'h10;
            6: c = 6'h20;
            default: c = 6'h01;
        endcase
        return {24'h0, fifo, fifo, c};
    endfunction

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] got;
        host.access(1'b0, a, 32'h0, 4'hF, got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] unused;
        host.access(1'b1, a, d, b, unused);
    endtask

    task automatic pulse(input logic [6:0] m);
        @(posedge i_clock);
        src <= m;
        @(posedge i_clock);
        src <= 7'h00;
    endtask

    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 8000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    // ========================================================================
    // Scenarios
    // ========================================================================
    initial begin
        logic [6:0] m;
        int         k;
        seed = 32'hE791DA4D;
        repeat (10) @(posedge i_clock);
        i_rst_n <= 1'b1;
        rd_chk(OFS_ISR, 32'h01, "isr after reset");
        rd_chk(OFS_IRQ_ENABLE, 32'h0, "enable after reset");
        rd_chk(OFS_FIFO_SETUP, 32'h0, "fifo setup after reset");
        rd_chk(OFS_ENH_FEAT, 32'h0, "enhanced after reset");
        rd_chk(5'h14, 32'h0, "unmapped read");
        wr_reg(OFS_IRQ_ENABLE, 32'h7F, 4'h0);
        rd_chk(OFS_IRQ_ENABLE, 32'h0, "write without byte enable");
        wr_reg(OFS_ISR, 32'hFF, 4'hF);
        rd_chk(OFS_ISR, 32'h01, "isr is read only");
        $display("test reset done");
        wr_reg(OFS_IRQ_ENABLE, 32'h7E, 4'hF);
        pulse(7'h41);
        rd_chk(OFS_ISR, 32'h01, "masked line and gated flow");
        wr_reg(OFS_IRQ_ENABLE, 32'h7F, 4'hF);
        wr_reg(OFS_ENH_FEAT, 32'h10, 4'hF);
        rd_chk(OFS_ISR, isr_of(0, 1'b0), "line after enable");
        rd_chk(OFS_ISR, isr_of(6, 1'b0), "flow after gate opens");
        rd_chk(OFS_ISR, 32'h01, "idle after drain");
        $display("test masking done");
        for (int i = 0; i < 7; i++) begin
            pulse(7'h01 << i);
            rd_chk(OFS_ISR, isr_of(i, 1'b0), "single source code");
            if (i == 5) begin
                rd_chk(OFS_ISR, isr_of(5, 1'b0), "xoff held over read");
                @(posedge i_clock);
                xon <= 1'b1;
                @(posedge i_clock);
                xon <= 1'b0;
            end
            rd_chk(OFS_ISR, 32'h01, "cleared by read");
        end
        $display("test codes done");
        for (int t = 0; t < 10; t++) begin
            m = 7'($random(seed)) & 7'h5F;
            if (t == 0) m = 7'h5F;
            pulse(m);
            while (m != 7'h00) begin
                k = 0;
                while (!m[k]) k++;
                rd_chk(OFS_ISR, isr_of(k, 1'b0), "priority order");
                m[k] = 1'b0;
            end
            rd_chk(OFS_ISR, 32'h01, "drained");
        end
        $display("test random priority done");
        pulse(7'h08);
        repeat (3) @(posedge i_clock);
        pulse(7'h01);
        rd_chk(OFS_ISR, isr_of(3, 1'b0), "reported source held");
        rd_chk(OFS_ISR, isr_of(0, 1'b0), "higher after clear");
        rd_chk(OFS_ISR, 32'h01, "idle");
        $display("test hold done");
        wr_reg(OFS_FIFO_SETUP, 32'h01, 4'hF);
        rd_chk(OFS_ISR, 32'hC1, "fifo enabled idle");
        @(posedge i_clock);
        rxc <= 6'h08;
        rd_chk(OFS_ISR, isr_of(1, 1'b1), "rx trigger reached");
        rd_chk(OFS_ISR, 32'hC1, "rx cleared");
        @(posedge i_clock);
        txc <= 6'h0F;
        rd_chk(OFS_ISR, isr_of(3, 1'b1), "tx below trigger");
        rd_chk(OFS_ISR, 32'hC1, "tx cleared");
        wr_reg(OFS_FIFO_SETUP, 32'hD1, 4'hF);
        rd_chk(OFS_FIFO_SETUP, 32'hD1, "fifo setup readback");
        @(posedge i_clock);
        rxc <= 6'h1C;
        txc <= 6'h07;
        rd_chk(OFS_PENDING, 32'h0A, "pending flags");
        rd_chk(OFS_ISR, isr_of(1, 1'b1), "rx trigger 28");
        rd_chk(OFS_ISR, isr_of(3, 1'b1), "tx below 8");
        wr_reg(OFS_FIFO_SETUP, 32'h00, 4'hF);
        rd_chk(OFS_ISR, 32'h01, "fifo disabled");
        $display("test fifo done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
